// ---- rtl/ffg_grid_index.sv ----
// Grid record index tracker that follows the ensemble CIF count.
`timescale 1ns/100ps
`default_nettype none
module ffg_grid_index (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cif_strobe,
  input wire logic [12:0] cif_count,
  output logic [8:0] rec_idx,
  output logic aligned
);

  logic [8:0] idx_q;
  logic [8:0] idx_d;
  logic aligned_q;
  wire logic at_zero;

  // ****************************************************************
  // Index arithmetic
  // ****************************************************************
  // Realigning on every zero boundary keeps us in step even if a CIF was missed.
  assign at_zero = (cif_count[8:0] & ffg_pkg::ALIGN_MASK) == 9'h000;
  assign idx_d = at_zero ? 9'h000 :
                 (idx_q == ffg_pkg::LAST_RECORD) ? 9'h000 : idx_q + 9'h001;

  // Index of the frame most recently strobed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 9'h000;
      aligned_q <= 1'b0;
    end else if (cif_strobe) begin
      idx_q <= idx_d;
      aligned_q <= aligned_q | at_zero;
    end
  end

  assign rec_idx = idx_q;
  assign aligned = aligned_q;

endmodule
`default_nettype wire

// ---- rtl/ffg_pkg.sv ----
// Shared constants, message carriers and decoders for the upstream grid and FIG file controller.
package ffg_pkg;

  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int GRID_RECORDS = 500;
  localparam int RECS_PER_MSG = 50;
  localparam logic [3:0] REC_MSGS = 4'ha;
  localparam logic [3:0] REC_OVER = 4'hb;
  localparam logic [8:0] LAST_RECORD = 9'h1f3;
  localparam logic [8:0] ALIGN_MASK = 9'h1ff;
  localparam logic [3:0] STREAM_TID = 4'h5;
  localparam logic [2:0] STREAM_TIDEXT = 3'h1;
  localparam int NAME_BITS = 128;
  localparam int CAUSE_BITS = 56;
  localparam int ALLOC_BITS = 200;

  // ****************************************************************
  // Cause strings, space padded, first character in the top byte
  // ****************************************************************
  localparam logic [55:0] CAUSE_UNKNOWN = 56'h554e4b4e4f574e;
  localparam logic [55:0] CAUSE_NRECORD = 56'h4e5245434f5244;
  localparam logic [55:0] CAUSE_USED = 56'h55534544202020;
  localparam logic [55:0] CAUSE_NOSPACE = 56'h4e4f5350414345;
  localparam logic [55:0] CAUSE_FIGCAP = 56'h46494743415020;
  localparam logic [55:0] CAUSE_CONTENT = 56'h434f4e54454e54;
  localparam logic [55:0] CAUSE_NREC = 56'h4e524543202020;
  localparam logic [55:0] CAUSE_GRID = 56'h47524944202020;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    FFG_MSG_NONE = 4'h0,
    FFG_MSG_FF_DES = 4'h1,
    FFG_MSG_FF_ERR = 4'h2,
    FFG_MSG_FF_OTHER = 4'h3,
    FFG_MSG_FG_INF = 4'h4,
    FFG_MSG_FG_DEF = 4'h5,
    FFG_MSG_FG_REC = 4'h6,
    FFG_MSG_FG_END = 4'h7,
    FFG_MSG_FG_ACT = 4'h8,
    FFG_MSG_FG_ERR = 4'h9
  } ffg_msg_kind_type;

  typedef enum logic [3:0] {
    FFG_CAUSE_NONE = 4'h0,
    FFG_CAUSE_UNKNOWN = 4'h1,
    FFG_CAUSE_NRECORD = 4'h2,
    FFG_CAUSE_USED = 4'h3,
    FFG_CAUSE_NOSPACE = 4'h4,
    FFG_CAUSE_FIGCAP = 4'h5,
    FFG_CAUSE_CONTENT = 4'h6,
    FFG_CAUSE_NREC = 4'h7,
    FFG_CAUSE_GRID = 4'h8,
    FFG_CAUSE_OTHER = 4'h9
  } ffg_cause_type;

  typedef enum logic [1:0] {
    FFG_GS_IDLE = 2'b00,
    FFG_GS_WAIT = 2'b01,
    FFG_GS_RECV = 2'b10
  } ffg_gs_state_type;

  // One control message; unused fields are don't-care for a given kind.
  typedef struct packed {
    ffg_msg_kind_type kind;
    logic [127:0] name;
    logic [4:0] name_len;
    logic [55:0] cause;
    logic [199:0] alloc;
    logic [16:0] act_sec;
  } ffg_msg_type;

  // Maps a received cause string onto the cause enumeration.
  function automatic ffg_cause_type ffg_cause_decode(input logic [55:0] s);
    ffg_cause_type c;
    c = FFG_CAUSE_OTHER;
    if (s == CAUSE_UNKNOWN) c = FFG_CAUSE_UNKNOWN;
    if (s == CAUSE_NRECORD) c = FFG_CAUSE_NRECORD;
    if (s == CAUSE_USED) c = FFG_CAUSE_USED;
    if (s == CAUSE_NOSPACE) c = FFG_CAUSE_NOSPACE;
    if (s == CAUSE_FIGCAP) c = FFG_CAUSE_FIGCAP;
    if (s == CAUSE_CONTENT) c = FFG_CAUSE_CONTENT;
    if (s == CAUSE_NREC) c = FFG_CAUSE_NREC;
    if (s == CAUSE_GRID) c = FFG_CAUSE_GRID;
    return c;
  endfunction

endpackage

// ---- rtl/ffg_upstream.sv ----
// Upstream controller for FIG file deselect, FIG file errors and the FIB grid protocol.
`timescale 1ns/100ps
`default_nettype none
module ffg_upstream (
  input wire logic clock,
  input wire logic rst_n,
  // Received control messages, one per strobe.
  input wire logic rx_valid,
  input wire ffg_pkg::ffg_msg_type rx_msg,
  // Transmitted control messages.
  output logic tx_valid,
  output ffg_pkg::ffg_msg_type tx_msg,
  input wire logic tx_ready,
  // User deselect request.
  input wire logic des_req,
  input wire logic [127:0] des_name,
  input wire logic [4:0] des_name_len,
  output logic des_ready,
  // User grid information request.
  input wire logic ginf_req,
  output logic ginf_ready,
  // Open FIG file session flag from the FIG file transfer logic.
  input wire logic fig_session_open,
  output logic fig_abort,
  // Error report.
  output logic err_evt,
  output logic err_from_grid,
  output ffg_pkg::ffg_cause_type err_cause,
  output logic [127:0] err_name,
  // Ensemble timing.
  input wire logic cif_strobe,
  input wire logic [12:0] cif_count,
  input wire logic [16:0] utc_sec,
  // Grid status.
  output logic grid_stored,
  output logic grid_active,
  output logic act_pending,
  output logic [3:0] fib_grant,
  // FIB stream gating.
  input wire logic fib_in_valid,
  input wire logic [1:0] fib_slot,
  output logic fib_out_valid,
  output logic [3:0] fib_tid,
  output logic [2:0] fib_tidext
);

  // ****************************************************************
  // State
  // ****************************************************************
  ffg_pkg::ffg_gs_state_type gs_q;
  ffg_pkg::ffg_gs_state_type gs_d;
  logic [3:0] rcnt_q;
  logic [3:0] rcnt_d;
  logic tx_valid_q;
  ffg_pkg::ffg_msg_type tx_msg_q;
  logic gerr_pend_q;
  logic [55:0] gerr_cause_q;
  logic stored_q;
  logic stored_bank_q;
  logic active_q;
  logic active_bank_q;
  logic pend_q;
  logic [16:0] pend_sec_q;
  logic [3:0] grant_q;
  logic err_evt_q;
  logic err_grid_q;
  ffg_pkg::ffg_cause_type err_cause_q;
  logic [127:0] err_name_q;
  logic fig_abort_q;
  logic [3:0] grid_mem [0:1][0:ffg_pkg::GRID_RECORDS-1];
  wire logic [8:0] rec_idx;
  wire logic idx_aligned;
  ffg_grid_index u_index (
    .clock(clock),
    .rst_n(rst_n),
    .cif_strobe(cif_strobe),
    .cif_count(cif_count),
    .rec_idx(rec_idx),
    .aligned(idx_aligned)
  );

  // ****************************************************************
  // Receive decode
  // ****************************************************************
  wire logic rx_def;
  wire logic rx_rec;
  wire logic rx_end;
  wire logic rx_act;
  wire logic rx_gerr;
  wire logic rx_ferr;
  wire logic in_recv;
  wire logic rec_write;
  wire logic nrec_err;
  wire logic grid_err;
  wire logic store_ok;
  wire logic wbank;
  wire logic [8:0] wbase;
  assign rx_def = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FG_DEF);
  assign rx_rec = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FG_REC);
  assign rx_end = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FG_END);
  assign rx_act = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FG_ACT);
  assign rx_gerr = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FG_ERR);
  assign rx_ferr = rx_valid && (rx_msg.kind == ffg_pkg::FFG_MSG_FF_ERR);
  assign in_recv = (gs_q == ffg_pkg::FFG_GS_RECV);

  // Records beyond the tenth are never written and the count stops at eleven, so an overlong session cannot spill.
  assign rec_write = rx_rec && in_recv && (rcnt_q < ffg_pkg::REC_MSGS);
  // A stray record or an end after the wrong count both draw the record-count error.
  assign nrec_err = (rx_rec && !in_recv) || (rx_end && in_recv && (rcnt_q != ffg_pkg::REC_MSGS));
  assign store_ok = rx_end && in_recv && (rcnt_q == ffg_pkg::REC_MSGS);
  // Activation without a stored grid is refused with the no-grid cause.
  assign grid_err = rx_act && !stored_q;
  // The bank in use is never overwritten by a new session.
  assign wbank = ~active_bank_q;
  assign wbase = 9'(rcnt_q * 6'(ffg_pkg::RECS_PER_MSG));

  // ****************************************************************
  // Grid session state machine
  // ****************************************************************
  // Grid definitions, records, ends and activations arrive from downstream; this side sends grid requests and grid errors.
  always_comb begin
    gs_d = gs_q;
    rcnt_d = rcnt_q;
    unique case (gs_q)
      ffg_pkg::FFG_GS_IDLE: begin
        if (ginf_req && ginf_ready) begin
          gs_d = ffg_pkg::FFG_GS_WAIT;
        end
        if (rx_def) begin
          gs_d = ffg_pkg::FFG_GS_RECV;
          rcnt_d = 4'h0;
        end
      end
      ffg_pkg::FFG_GS_WAIT: begin
        if (rx_def) begin
          gs_d = ffg_pkg::FFG_GS_RECV;
          rcnt_d = 4'h0;
        end else if (rx_gerr) begin
          gs_d = ffg_pkg::FFG_GS_IDLE;
        end
      end
      ffg_pkg::FFG_GS_RECV: begin
        if (rx_rec && rcnt_q != ffg_pkg::REC_OVER) begin
          rcnt_d = rcnt_q + 4'h1;
        end
        if (rx_end || rx_gerr) begin
          gs_d = ffg_pkg::FFG_GS_IDLE;
        end
      end
      default: begin
        gs_d = ffg_pkg::FFG_GS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gs_q <= ffg_pkg::FFG_GS_IDLE;
      rcnt_q <= 4'h0;
    end else begin
      gs_q <= gs_d;
      rcnt_q <= rcnt_d;
    end
  end

  // ****************************************************************
  // Grid store
  // ****************************************************************
  // Each record message lands fifty nibbles, first record from the top of the field.
  always_ff @(posedge clock) begin
    if (rec_write) begin
      for (int g = 0; g < ffg_pkg::RECS_PER_MSG; g++) begin
        grid_mem[wbank][wbase + 9'(g)] <= rx_msg.alloc[ffg_pkg::ALLOC_BITS - 1 - 4 * g -: 4];
      end
    end
  end

  // Stored and active flags with the pending activation.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stored_q <= 1'b0;
      stored_bank_q <= 1'b1;
      active_q <= 1'b0;
      active_bank_q <= 1'b0;
      pend_q <= 1'b0;
      pend_sec_q <= 17'h00000;
    end else begin
      if (rx_def) begin
        stored_q <= 1'b0;
        pend_q <= 1'b0;  // Its bank is about to be overwritten.
      end
      if (store_ok) begin
        stored_q <= 1'b1;
        stored_bank_q <= wbank;
      end
      // Swap happens on the strobe that realigns the index; an activation taken then stays pending.
      if (pend_q && cif_strobe && cif_count[8:0] == 9'h000 && utc_sec > pend_sec_q) begin
        pend_q <= 1'b0;
        active_q <= 1'b1;
        active_bank_q <= stored_bank_q;
      end
      if (rx_act && stored_q) begin
        pend_q <= 1'b1;
        pend_sec_q <= rx_msg.act_sec;
      end
    end
  end

  // ****************************************************************
  // FIB access
  // ****************************************************************
  // Grant is resampled every cycle so it follows the index one cycle after each strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      grant_q <= 4'h0;
    end else begin
      grant_q <= (active_q && idx_aligned) ? grid_mem[active_bank_q][rec_idx] : 4'h0;
    end
  end

  wire logic [1:0] grant_bit;
  assign grant_bit = 2'h3 - fib_slot;
  assign fib_out_valid = fib_in_valid && grant_q[grant_bit];
  assign fib_tid = ffg_pkg::STREAM_TID;
  assign fib_tidext = ffg_pkg::STREAM_TIDEXT;

  // ****************************************************************
  // Transmit arbitration
  // ****************************************************************
  // Own grid error outranks user traffic so that the session close is answered promptly.
  wire logic tx_free;
  wire logic load_gerr;
  wire logic load_des;
  wire logic load_inf;
  wire logic gerr_set;
  assign tx_free = !tx_valid_q || tx_ready;
  assign load_gerr = tx_free && gerr_pend_q;
  assign des_ready = tx_free && !gerr_pend_q;
  assign load_des = des_req && des_ready;
  assign ginf_ready = tx_free && !gerr_pend_q && !des_req && (gs_q == ffg_pkg::FFG_GS_IDLE);
  assign load_inf = ginf_req && ginf_ready;
  assign gerr_set = nrec_err || grid_err;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gerr_pend_q <= 1'b0;
      gerr_cause_q <= ffg_pkg::CAUSE_NREC;
    end else begin
      // A new error in the cycle that the old one is sent stays pending.
      if (gerr_set) begin
        gerr_pend_q <= 1'b1;
        gerr_cause_q <= nrec_err ? ffg_pkg::CAUSE_NREC : ffg_pkg::CAUSE_GRID;
      end else if (load_gerr) begin
        gerr_pend_q <= 1'b0;
      end
    end
  end

  // Message register; holds until the link takes it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_q <= 1'b0;
      tx_msg_q <= '0;
    end else if (tx_free) begin
      tx_valid_q <= load_gerr || load_des || load_inf;
      tx_msg_q <= '0;
      if (load_gerr) begin
        tx_msg_q.kind <= ffg_pkg::FFG_MSG_FG_ERR;
        tx_msg_q.cause <= gerr_cause_q;
      end else if (load_des) begin
        tx_msg_q.kind <= ffg_pkg::FFG_MSG_FF_DES;
        tx_msg_q.name <= des_name;
        tx_msg_q.name_len <= des_name_len;
      end else if (load_inf) begin
        tx_msg_q.kind <= ffg_pkg::FFG_MSG_FG_INF;
      end
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_msg = tx_msg_q;

  // ****************************************************************
  // Error reporting
  // ****************************************************************
  // Received FIG file errors carry name and cause; an open FIG session is aborted.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_evt_q <= 1'b0;
      err_grid_q <= 1'b0;
      err_cause_q <= ffg_pkg::FFG_CAUSE_NONE;
      err_name_q <= '0;
      fig_abort_q <= 1'b0;
    end else begin
      err_evt_q <= rx_ferr || rx_gerr;
      fig_abort_q <= rx_ferr && fig_session_open;
      if (rx_ferr) begin
        err_grid_q <= 1'b0;
        err_cause_q <= ffg_pkg::ffg_cause_decode(rx_msg.cause);
        err_name_q <= rx_msg.name;
      end else if (rx_gerr) begin
        err_grid_q <= 1'b1;
        err_cause_q <= ffg_pkg::ffg_cause_decode(rx_msg.cause);
        err_name_q <= '0;
      end
    end
  end

  assign err_evt = err_evt_q;
  assign err_from_grid = err_grid_q;
  assign err_cause = err_cause_q;
  assign err_name = err_name_q;
  assign fig_abort = fig_abort_q;
  assign grid_stored = stored_q;
  assign grid_active = active_q;
  assign act_pending = pend_q;
  assign fib_grant = grant_q;

endmodule
`default_nettype wire

// ---- tb/ffg_dn_model.sv ----
// Behavioural downstream entity that takes control messages and answers them.
`timescale 1ns/100ps
`default_nettype none
module ffg_dn_model #(
  parameter logic [127:0] SEL_NAME = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire ffg_pkg::ffg_msg_type tx_msg,
  output logic tx_ready,
  output logic rx_valid,
  output ffg_pkg::ffg_msg_type rx_msg,
  input wire logic slow
);
  // ********************
  // Stored state and outgoing queue
  // ********************
  ffg_pkg::ffg_msg_type q[$];
  ffg_pkg::ffg_msg_type last_tx = '0;
  logic sel_flag = 1'b1; // The one stored file starts out selected.
  logic have_grid = 1'b0;

  // Grid transfer: open, records of fifty nibbles from record zero on, close.
  task automatic send_grid(input int recs, input logic abort);
    ffg_pkg::ffg_msg_type r;
    r = '0;
    r.kind = ffg_pkg::FFG_MSG_FG_DEF;
    q.push_back(r);
    for (int k = 0; k < recs; k++) begin
      r.kind = ffg_pkg::FFG_MSG_FG_REC;
      r.alloc = {50{4'(k) ^ 4'ha}};
      q.push_back(r);
    end
    if (abort) begin
      r.kind = ffg_pkg::FFG_MSG_FG_ERR;
      r.cause = ffg_pkg::CAUSE_NREC;
      q.push_back(r);
    end
    r.kind = ffg_pkg::FFG_MSG_FG_END;
    q.push_back(r);
  endtask

  // Answers a message taken from the controller.
  task automatic take(input ffg_pkg::ffg_msg_type t);
    ffg_pkg::ffg_msg_type r;
    r = '0;
    r.name = t.name;
    if (t.kind == ffg_pkg::FFG_MSG_FF_DES && sel_flag && t.name == SEL_NAME) begin
      sel_flag = 1'b0; // Broadcast of the file stops here.
    end else if (t.kind == ffg_pkg::FFG_MSG_FF_DES) begin
      r.kind = ffg_pkg::FFG_MSG_FF_ERR;
      r.cause = ffg_pkg::CAUSE_UNKNOWN;
      q.push_back(r);
    end else if (t.kind == ffg_pkg::FFG_MSG_FG_INF && have_grid) begin
      send_grid(10, 1'b0);
    end else if (t.kind == ffg_pkg::FFG_MSG_FG_INF) begin
      r.kind = ffg_pkg::FFG_MSG_FG_ERR; // No grid to offer.
      r.cause = ffg_pkg::CAUSE_GRID;
      q.push_back(r);
    end
  endtask

  // When slow, ready drops on alternate cycles to test holding.
  // Queued messages leave one per cycle; activation only ever comes from here.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_msg <= '0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        last_tx <= tx_msg;
        take(tx_msg);
      end
      if (q.size() != 0) begin
        rx_valid <= 1'b1;
        rx_msg <= q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_msg <= ~rx_msg; // Stale message lines toggle so nothing can lean on them.
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/ffg_upstream_checker.sv ----
// Port-level assertions for the upstream grid and FIG file controller.
`timescale 1ns/100ps
`default_nettype none
module ffg_upstream_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire ffg_pkg::ffg_msg_type rx_msg,
  input wire logic tx_valid,
  input wire ffg_pkg::ffg_msg_type tx_msg,
  input wire logic des_req,
  input wire logic [127:0] des_name,
  input wire logic des_ready,
  input wire logic ginf_req,
  input wire logic ginf_ready,
  input wire logic fig_session_open,
  input wire logic fig_abort,
  input wire logic err_evt,
  input wire logic err_from_grid,
  input wire logic [127:0] err_name,
  input wire logic cif_strobe,
  input wire logic [12:0] cif_count,
  input wire logic grid_stored,
  input wire logic grid_active,
  input wire logic [3:0] fib_grant,
  input wire logic fib_in_valid,
  input wire logic [1:0] fib_slot,
  input wire logic fib_out_valid,
  input wire logic [3:0] fib_tid,
  input wire logic [2:0] fib_tidext
);
  // ********************
  // Properties
  // ********************
  // One clock domain, so clocking and reset are given once for all checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  tid_fixed_a: assert property (fib_tid == 4'h5 && fib_tidext == 3'h1)
    else $error("stream ids wrong");
  fib_gate_a: assert property (fib_out_valid == (fib_in_valid && fib_grant[2'd3 - fib_slot]))
    else $error("fib gate wrong");
  act_align_a: assert property ($rose(grid_active) |-> $past(cif_strobe) && $past(cif_count[8:0]) == 9'h0)
    else $error("grid start not aligned");
  fig_abort_a: assert property (rx_valid && rx_msg.kind == ffg_pkg::FFG_MSG_FF_ERR
    |=> fig_abort == $past(fig_session_open)) else $error("abort pulse wrong");
  grid_err_a: assert property (rx_valid && rx_msg.kind == ffg_pkg::FFG_MSG_FG_ERR
    |=> err_evt && err_from_grid) else $error("grid error not reported");
  file_err_a: assert property (rx_valid && rx_msg.kind == ffg_pkg::FFG_MSG_FF_ERR
    |=> err_evt && !err_from_grid && err_name == $past(rx_msg.name)) else $error("file error wrong");
  des_send_a: assert property (des_req && des_ready
    |=> tx_valid && tx_msg.kind == ffg_pkg::FFG_MSG_FF_DES && tx_msg.name == $past(des_name))
    else $error("deselect not sent");
  inf_send_a: assert property (ginf_req && ginf_ready |=> tx_valid && tx_msg.kind == ffg_pkg::FFG_MSG_FG_INF)
    else $error("grid request not sent");
  tx_kind_a: assert property (tx_valid |-> tx_msg.kind inside {ffg_pkg::FFG_MSG_FF_DES,
    ffg_pkg::FFG_MSG_FG_INF, ffg_pkg::FFG_MSG_FG_ERR}) else $error("illegal message sent");
  grid_store_a: assert property ($rose(grid_stored) |-> $past(rx_valid)
    && $past(rx_msg.kind) == ffg_pkg::FFG_MSG_FG_END) else $error("grid stored without end");
endmodule

bind ffg_upstream ffg_upstream_checker chk (.clock, .rst_n, .rx_valid, .rx_msg, .tx_valid, .tx_msg, .des_req,
  .des_name, .des_ready, .ginf_req, .ginf_ready, .fig_session_open, .fig_abort, .err_evt, .err_from_grid,
  .err_name, .cif_strobe, .cif_count, .grid_stored, .grid_active, .fib_grant, .fib_in_valid, .fib_slot,
  .fib_out_valid, .fib_tid, .fib_tidext);
`default_nettype wire

// ---- tb/ffg_upstream_tb_top.sv ----
// Self-checking bench for the upstream grid and FIG file controller.
`timescale 1ns/100ps
`default_nettype none
module ffg_upstream_tb_top;
  // ********************
  // Signals and instances
  // ********************
  localparam logic [127:0] FILE_NAME = {32'h6e657773, 96'h0};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic des_req = 1'b0;
  logic ginf_req = 1'b0;
  logic fig_session_open = 1'b0;
  logic cif_strobe = 1'b0;
  logic fib_in_valid = 1'b0;
  logic slow = 1'b0;
  logic [127:0] des_name = '0;
  logic [4:0] des_name_len = 5'h04;
  logic [12:0] cif_count = '0;
  logic [16:0] utc_sec = '0;
  logic [1:0] fib_slot = '0;
  logic rx_valid, tx_valid, tx_ready, des_ready, ginf_ready, fig_abort, err_evt, err_from_grid;
  logic grid_stored, grid_active, act_pending, fib_out_valid;
  logic [127:0] err_name;
  logic [3:0] fib_grant, fib_tid;
  logic [2:0] fib_tidext;
  ffg_pkg::ffg_cause_type err_cause;
  ffg_pkg::ffg_msg_type rx_msg, tx_msg;
  int err_total = 0;
  int samples_checked = 0;
  int err_seen = 0;
  int abort_seen = 0;
  // Half-period toggle gives the 100 MHz clock.
  always #5 clock = ~clock;
  // Pulses last one cycle, so they are counted where they happen.
  always @(posedge clock) begin
    if (err_evt === 1'b1)
      err_seen++;
    if (fig_abort === 1'b1)
      abort_seen++;
  end

  ffg_upstream uut (.clock, .rst_n, .rx_valid, .rx_msg, .tx_valid, .tx_msg, .tx_ready, .des_req, .des_name,
    .des_name_len, .des_ready, .ginf_req, .ginf_ready, .fig_session_open, .fig_abort, .err_evt, .err_from_grid,
    .err_cause, .err_name, .cif_strobe, .cif_count, .utc_sec, .grid_stored, .grid_active, .act_pending,
    .fib_grant, .fib_in_valid, .fib_slot, .fib_out_valid, .fib_tid, .fib_tidext);
  ffg_dn_model #(.SEL_NAME(FILE_NAME)) mdl (.clock, .rst_n, .tx_valid, .tx_msg, .tx_ready, .rx_valid, .rx_msg,
    .slow);

  // ********************
  // Shared steps
  // ********************
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A wait that ran out counts against the run and ends it.
  task automatic hang();
    err_total++;
    test_done();
  endtask

  // Waits until both link directions are quiet, plus margin.
  task automatic settle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge clock);
      if (mdl.q.size() == 0 && tx_valid === 1'b0 && rx_valid === 1'b0)
        break;
    end
    if (i == 400)
      hang();
    repeat (5) @(negedge clock);
  endtask

  // Holds a user request until ready was seen high at a falling edge, then through the next rising edge.
  task automatic user_req(input logic inf, input logic [127:0] nm);
    logic ok;
    ok = 1'b0;
    @(posedge clock);
    ginf_req <= inf;
    des_req <= ~inf;
    des_name <= nm;
    for (int i = 0; i < 100 && ok !== 1'b1; i++) begin
      @(negedge clock);
      ok = inf ? ginf_ready : des_ready;
      @(posedge clock);
    end
    ginf_req <= 1'b0;
    des_req <= 1'b0;
    if (ok !== 1'b1)
      hang();
  endtask

  function automatic ffg_pkg::ffg_msg_type mk(input ffg_pkg::ffg_msg_kind_type k, input logic [55:0] c);
    ffg_pkg::ffg_msg_type r;
    r = '0;
    r.kind = k;
    r.name = FILE_NAME;
    r.name_len = 5'h04;
    r.cause = c;
    return r;
  endfunction

  // One CIF strobe, then long enough for that frame's grant to show.
  task automatic strobe(input logic [12:0] c);
    @(posedge clock);
    cif_strobe <= 1'b1;
    cif_count <= c;
    @(posedge clock);
    cif_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  // ********************
  // Scenarios
  // ********************
  // Deselect the selected file twice, the link stalling.
  task automatic t_deselect();
    @(posedge clock);
    slow <= 1'b1;
    user_req(1'b0, FILE_NAME);
    settle();
    check(mdl.last_tx.kind, ffg_pkg::FFG_MSG_FF_DES);
    check(mdl.last_tx.name, FILE_NAME);
    check(err_seen, 0);
    user_req(1'b0, FILE_NAME);
    settle();
    check(err_seen, 1);
    check(err_cause, ffg_pkg::FFG_CAUSE_UNKNOWN);
    check(err_name, FILE_NAME);
    check(err_from_grid, 1'b0);
    @(posedge clock);
    slow <= 1'b0;
  endtask

  // Every file cause string, every second one while a file session is open.
  task automatic t_causes();
    logic [55:0] txt [6];
    int n;
    txt = '{ffg_pkg::CAUSE_UNKNOWN, ffg_pkg::CAUSE_NRECORD, ffg_pkg::CAUSE_USED, ffg_pkg::CAUSE_NOSPACE,
      ffg_pkg::CAUSE_FIGCAP, ffg_pkg::CAUSE_CONTENT};
    for (int i = 0; i < 6; i++) begin
      n = abort_seen;
      @(posedge clock);
      fig_session_open <= i[0];
      mdl.q.push_back(mk(ffg_pkg::FFG_MSG_FF_ERR, txt[i]));
      settle();
      check(err_cause, 4'(i + 1));
      check(abort_seen - n, i % 2);
    end
    @(posedge clock);
    fig_session_open <= 1'b0;
  endtask

  // Activation with no stored grid draws a grid error back.
  task automatic t_act_nogrid();
    @(posedge clock);
    mdl.q.push_back(mk(ffg_pkg::FFG_MSG_FG_ACT, '0));
    settle();
    check(mdl.last_tx.kind, ffg_pkg::FFG_MSG_FG_ERR);
    check(mdl.last_tx.cause, ffg_pkg::CAUSE_GRID);
    check(act_pending, 1'b0);
  endtask

  // Grid session with a given record count, optionally broken off by a grid error.
  task automatic t_session(input int recs, input logic abort);
    int n;
    n = err_seen;
    @(posedge clock);
    mdl.send_grid(recs, abort);
    settle();
    check(grid_stored, recs == 10 && !abort);
    check(err_seen - n, abort);
    if (abort)
      check(err_cause, ffg_pkg::FFG_CAUSE_NREC);
    if (recs != 10 && !abort)
      check(mdl.last_tx.cause, ffg_pkg::CAUSE_NREC);
  endtask

  // Grid request, first with no grid on the far side, then with one.
  task automatic t_inf();
    int n;
    n = err_seen;
    user_req(1'b1, '0);
    settle();
    check(mdl.last_tx.kind, ffg_pkg::FFG_MSG_FG_INF);
    check(err_seen - n, 1);
    check(err_from_grid, 1'b1);
    check(err_cause, ffg_pkg::FFG_CAUSE_GRID);
    mdl.have_grid = 1'b1;
    user_req(1'b1, '0);
    settle();
    check(grid_stored, 1'b1);
  endtask

  // Activation waits for an aligned frame after the time; then the grid cycles.
  task automatic t_activate();
    ffg_pkg::ffg_msg_type a;
    a = mk(ffg_pkg::FFG_MSG_FG_ACT, '0);
    a.act_sec = 17'd100;
    @(posedge clock);
    utc_sec <= 17'd100;
    mdl.q.push_back(a);
    settle();
    check(act_pending, 1'b1);
    strobe(13'd512);
    check(grid_active, 1'b0);
    check(fib_grant, 4'h0);
    @(posedge clock);
    utc_sec <= 17'd101;
    strobe(13'd1024);
    check(grid_active, 1'b1);
    check(fib_grant, 4'ha);
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      fib_in_valid <= 1'b1;
      fib_slot <= 2'(s);
      @(negedge clock);
      check(fib_out_valid, !s[0]);
    end
    for (int k = 1; k <= 500; k++) begin
      strobe(13'(1024 + k));
      if (k == 50)
        check(fib_grant, 4'hb);
      if (k == 499)
        check(fib_grant, 4'h3);
    end
    check(fib_grant, 4'ha);
  endtask

  // Reset for five cycles, then run the scenarios in order.
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check(tx_valid, 1'b0);
    check(fib_tid, 4'h5);
    check(fib_tidext, 3'h1);
    t_deselect();
    t_causes();
    t_act_nogrid();
    t_session(9, 1'b0);
    t_session(11, 1'b0);
    t_session(3, 1'b1);
    t_inf();
    t_activate();
    test_done();
  end
endmodule
`default_nettype wire
